// >>> verilog/srg_pkg.sv
// Shared constants, types and decode helpers of the secure RAM guard.
// Assumes one clock domain; every block file imports this package whole.
package srg_pkg;

	// Geometry of the guarded memory
	localparam int SRG_ADDR_W = 6; // Word address width, 64 words
	localparam int SRG_LANES = 8; // Four data lanes plus four complement lanes

	// Register offsets on the plain register port
	localparam logic [7:0] SRG_OFF_CTRL = 8'h00; // control_a
	localparam logic [7:0] SRG_OFF_KEY = 8'h04; // scramble_key
	localparam logic [7:0] SRG_OFF_STATUS = 8'h08; // Status, read only
	localparam logic [7:0] SRG_OFF_FLAG = 8'h0C; // Sticky event flags
	localparam logic [7:0] SRG_OFF_MASK = 8'h10; // Interrupt mask

	// control_a field positions
	localparam int SRG_CTRL_SWRST = 0; // Write one: module software reset
	localparam int SRG_CTRL_ENABLE = 1; // Module enable
	localparam int SRG_CTRL_REMGRD = 2; // remanence_guard_enable
	localparam int SRG_CTRL_TAMPER = 3; // tamper_erase_enable

	// Status field positions
	localparam int SRG_STAT_INV = 0; // inversion_state
	localparam int SRG_STAT_REMBUSY = 1; // Remanence pass running
	localparam int SRG_STAT_ERASING = 2; // Erase running

	// Event flag positions, shared by flag and mask registers
	localparam int SRG_EV_PASS = 0; // Remanence pass finished
	localparam int SRG_EV_ERASE = 1; // Erase finished
	localparam int SRG_EV_BUSERR = 2; // Read returned a bus error
	localparam int SRG_EV_W = 3;

	// Reset values
	localparam logic [3:1] SRG_CTRL_RESET = 3'h0;
	localparam logic [SRG_ADDR_W-1:0] SRG_KEY_RESET = 6'h00;
	localparam logic [SRG_EV_W-1:0] SRG_EV_RESET = 3'h0;
	localparam logic [31:0] SRG_ERASE_DATA = 32'h0000_0000; // Data left by an erase

	// Access size on the memory port
	typedef enum logic [1:0] {SRG_SIZE_BYTE, SRG_SIZE_HALF, SRG_SIZE_WORD} srg_size_t;

	// One request on the memory port
	typedef struct packed {
		logic write;
		logic read;
		srg_size_t size;
		logic [7:0] addr;
		logic [31:0] wdata;
	} srg_mem_req_t;

	// Sequencer states
	typedef enum logic [1:0] {SRG_IDLE, SRG_REM_READ, SRG_REM_WRITE, SRG_ERASE} srg_state_t;

	// Byte lanes touched by a byte or half-word access
	function automatic logic [3:0] srg_lane_mask(input srg_size_t size, input logic [1:0] low);
		logic [3:0] m;
		m = 4'h0;
		if (size == SRG_SIZE_BYTE)
			m = 4'(4'h1 << low);
		else if (size == SRG_SIZE_HALF)
			m = low[1] ? 4'hC : 4'h3;
		return m;
	endfunction

	// Lane mask widened to a bit mask
	function automatic logic [31:0] srg_lane_bits(input logic [3:0] l);
		return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
	endfunction

endpackage

// >>> verilog/srg_word_ram.sv
// Word memory of the secure RAM guard: one write port with lane enables,
// one read port whose data come out of a register one cycle after the read.
// Assumes the caller never reads and writes in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module srg_word_ram
	import srg_pkg::*;
#(
	parameter int DEPTH = 64,
	parameter int ADDR_W = SRG_ADDR_W,
	parameter int LANES = SRG_LANES
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic wrEn,
	input wire logic [LANES-1:0] laneEn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [LANES*8-1:0] wrData,
	input wire logic rdEn,
	output logic [LANES*8-1:0] rdData
);

	// Storage has no reset; an erase pass gives it defined contents
	logic [LANES*8-1:0] mem [DEPTH];

	// Lane-wise write
	always_ff @(posedge sys_clk)
	begin
		for (int i = 0; i < LANES; i++)
		begin
			if (wrEn && laneEn[i])
				mem[addr][i*8 +: 8] <= wrData[i*8 +: 8];
		end
	end

	// Registered read; holds the last word between reads
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			rdData <= '0;
		else if (rdEn)
			rdData <= mem[addr];
	end

endmodule
`default_nettype wire

// >>> verilog/srg_addr_scrambler.sv
// Address scrambler: bit-reverses the word address and mixes in the key.
// Purely combinational; shared by processor and sequencer accesses.
`timescale 1ns/1ps
`default_nettype none
module srg_addr_scrambler
	import srg_pkg::*;
#(
	parameter int ADDR_W = SRG_ADDR_W
)
(
	input wire logic [ADDR_W-1:0] logicalAddr,
	input wire logic [ADDR_W-1:0] key,
	output logic [ADDR_W-1:0] physAddr
);

	// Reversed bit order breaks up linear sweeps
	logic [ADDR_W-1:0] reversed;

	genvar g;
	generate
		for (g = 0; g < ADDR_W; g++)
		begin : gRev
			assign reversed[g] = logicalAddr[ADDR_W-1-g];
		end
	endgenerate

	// Key mixing, a bijection for every key
	assign physAddr = reversed ^ key;

endmodule
`default_nettype wire

// >>> verilog/srg_guard_top.sv
// Secure RAM guard: complement-checked word memory, remanence inversion
// sequencer, tamper erase and a small register file with one interrupt.
// Assumes processor requests and RTC event pulses are on sys_clk.
//
// Summary of operation
// - Byte/half access; word writes dropped, reads zero
// - Writes store data and its complement
// - Reads check complement pair, else bus error
// - Remanence option frozen while module enabled
// - Daily tick starts remanence pass when enabled
// - Pass counter steps addresses 0 through 63
// - Each location read, inverted, written back
// - Counter goes through the address scrambler
// - Pass ends by toggling inversion state
// - Processor accesses pause the pass, then resume
// - Tamper aborts pass, counter returns to zero
// - Tamper option frozen while module enabled
// - Tamper acts as software reset, clears key
// - Erase returns all registers to reset
// - Erase writes zero into every location
`timescale 1ns/1ps
`default_nettype none
module srg_guard_top
	import srg_pkg::*;
#(
	parameter int ADDR_W = SRG_ADDR_W
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	input wire srg_mem_req_t memReq,
	output logic [31:0] memRdata,
	output logic memValid,
	output logic memError,
	input wire logic dailyTickEvent,
	input wire logic tamperEvent,
	output logic irq
);

	localparam int WORDS = 1 << ADDR_W;
	localparam logic [ADDR_W-1:0] LAST_ADDR = {ADDR_W{1'b1}};

	// Register state
	logic [3:1] ctrl_reg, ctrl_next; // Enable and option bits of control_a
	logic [ADDR_W-1:0] key_reg, key_next; // scramble_key
	logic [SRG_EV_W-1:0] flag_reg, flag_next; // Sticky events
	logic [SRG_EV_W-1:0] mask_reg, mask_next; // Interrupt mask
	logic inversion_reg, inversion_next; // inversion_state
	logic [WORDS-1:0] done_reg, done_next; // Locations already inverted this pass

	// Sequencer state
	srg_state_t state_reg, state_next;
	logic [ADDR_W-1:0] count_reg, count_next; // Pass and erase address counter

	// Read response state
	logic rdPending_reg, rdPending_next; // Answer due this cycle
	logic rdZero_reg, rdZero_next; // Word read, answer zero
	logic rdErase_reg, rdErase_next; // Read during erase, answer error
	logic [3:0] rdLanes_reg, rdLanes_next; // Lanes asked for
	logic rdInv_reg, rdInv_next; // Inversion in force for that location
	logic [31:0] regRdata_next;

	// Decoded request and event terms
	logic enabled;
	logic isWord;
	logic erasing;
	logic cpuRamWrite;
	logic cpuRamRead;
	logic cpuUsesRam;
	logic [3:0] cpuLanes;
	logic swrstHit;
	logic tamperHit;
	logic eraseStart;
	logic passDone;
	logic eraseDone;
	logic remCommit;
	logic effInv;
	logic [31:0] invWord;
	logic [31:0] storeData;

	// Memory port
	logic [ADDR_W-1:0] logicalAddr;
	logic [ADDR_W-1:0] physAddr;
	logic ramWrEn;
	logic ramRdEn;
	logic [SRG_LANES-1:0] ramLaneEn;
	logic [SRG_LANES*8-1:0] ramWrData;
	logic [SRG_LANES*8-1:0] ramRdData;

	// Read-back terms
	logic [31:0] rdBits;
	logic [31:0] trueData;
	logic [31:0] trueComp;
	logic mismatch;

	// Request decode
	assign enabled = ctrl_reg[SRG_CTRL_ENABLE];
	assign erasing = (state_reg == SRG_ERASE);
	assign isWord = (memReq.size == SRG_SIZE_WORD);
	assign cpuLanes = srg_lane_mask(memReq.size, memReq.addr[1:0]);
	assign cpuRamWrite = memReq.write && !isWord && !erasing;
	assign cpuRamRead = memReq.read && !isWord && !erasing;
	assign cpuUsesRam = cpuRamWrite || cpuRamRead;

	// Erase triggers: software reset bit or tamper with the option on
	assign swrstHit = regWrite && (regAddr == SRG_OFF_CTRL) && regWdata[SRG_CTRL_SWRST];
	assign tamperHit = tamperEvent && enabled && ctrl_reg[SRG_CTRL_TAMPER];
	assign eraseStart = swrstHit || tamperHit;

	// The processor owns the address mux whenever it touches memory
	assign logicalAddr = cpuUsesRam ? memReq.addr[7:2] : count_reg;

	// One scrambler for both paths keeps the mapping identical
	srg_addr_scrambler #(
		.ADDR_W(ADDR_W)
	) uScrambler (
		.logicalAddr(logicalAddr),
		.key(key_reg),
		.physAddr(physAddr)
	);

	// A location already flipped in this pass carries the next polarity
	assign effInv = inversion_reg ^ done_reg[physAddr];
	assign invWord = {32{effInv}};
	assign storeData = memReq.wdata ^ invWord;

	// Memory port control; erase first, then processor, then the pass
	always_comb
	begin
		ramWrEn = 1'b0;
		ramRdEn = 1'b0;
		ramLaneEn = '0;
		ramWrData = '0;
		if (erasing)
		begin
			// Zero data beside a valid complement, so reads succeed
			ramWrEn = 1'b1;
			ramLaneEn = '1;
			ramWrData = {~SRG_ERASE_DATA, SRG_ERASE_DATA};
		end
		else if (cpuRamWrite)
		begin
			// Data and complement land in matching lanes
			ramWrEn = 1'b1;
			ramLaneEn = {cpuLanes, cpuLanes};
			ramWrData = {~storeData, storeData};
		end
		else if (cpuRamRead)
		begin
			ramRdEn = 1'b1;
		end
		else if (state_reg == SRG_REM_READ)
		begin
			ramRdEn = 1'b1;
		end
		else if (state_reg == SRG_REM_WRITE)
		begin
			// Flipping both halves keeps the pair complementary
			ramWrEn = 1'b1;
			ramLaneEn = '1;
			ramWrData = ~ramRdData;
		end
	end

	srg_word_ram #(
		.DEPTH(WORDS),
		.ADDR_W(ADDR_W),
		.LANES(SRG_LANES)
	) uRam (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.wrEn(ramWrEn),
		.laneEn(ramLaneEn),
		.addr(physAddr),
		.wrData(ramWrData),
		.rdEn(ramRdEn),
		.rdData(ramRdData)
	);

	// Remanence write is committed only when the processor leaves the port free
	assign remCommit = (state_reg == SRG_REM_WRITE) && !cpuUsesRam && !eraseStart;
	assign passDone = remCommit && (count_reg == LAST_ADDR);
	assign eraseDone = erasing && !eraseStart && (count_reg == LAST_ADDR);

	// Sequencer next state
	always_comb
	begin
		state_next = state_reg;
		count_next = count_reg;
		case (state_reg)
			SRG_IDLE:
			begin
				if (dailyTickEvent && enabled && ctrl_reg[SRG_CTRL_REMGRD])
				begin
					state_next = SRG_REM_READ;
					count_next = '0;
				end
			end
			SRG_REM_READ:
			begin
				// Wait while the processor holds the port
				if (!cpuUsesRam)
					state_next = SRG_REM_WRITE;
			end
			SRG_REM_WRITE:
			begin
				if (cpuUsesRam)
				begin
					// The fetched word may be stale now, so fetch again
					state_next = SRG_REM_READ;
				end
				else if (count_reg == LAST_ADDR)
				begin
					state_next = SRG_IDLE;
				end
				else
				begin
					count_next = count_reg + 1'b1;
					state_next = SRG_REM_READ;
				end
			end
			SRG_ERASE:
			begin
				if (count_reg == LAST_ADDR)
					state_next = SRG_IDLE;
				else
					count_next = count_reg + 1'b1;
			end
			default:
			begin
				state_next = SRG_IDLE;
				count_next = '0;
			end
		endcase
		// Tamper or software reset overrides any pass in flight
		if (eraseStart)
		begin
			state_next = SRG_ERASE;
			count_next = '0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= SRG_IDLE;
			count_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			count_reg <= count_next;
		end
	end

	// Register file next values
	always_comb
	begin
		ctrl_next = ctrl_reg;
		key_next = key_reg;
		flag_next = flag_reg;
		mask_next = mask_reg;
		inversion_next = inversion_reg;
		done_next = done_reg;
		if (regWrite)
		begin
			case (regAddr)
				SRG_OFF_CTRL:
				begin
					ctrl_next[SRG_CTRL_ENABLE] = regWdata[SRG_CTRL_ENABLE];
					// Options only change while the module is off
					if (!enabled)
					begin
						ctrl_next[SRG_CTRL_REMGRD] = regWdata[SRG_CTRL_REMGRD];
						ctrl_next[SRG_CTRL_TAMPER] = regWdata[SRG_CTRL_TAMPER];
					end
				end
				SRG_OFF_KEY:
				begin
					key_next = regWdata[ADDR_W-1:0];
				end
				SRG_OFF_FLAG:
				begin
					flag_next = flag_reg & ~regWdata[SRG_EV_W-1:0];
				end
				SRG_OFF_MASK:
				begin
					mask_next = regWdata[SRG_EV_W-1:0];
				end
				default:
				begin
					ctrl_next = ctrl_reg;
				end
			endcase
		end
		// Hardware sets come after the clear, so a same-cycle event survives
		if (passDone)
			flag_next[SRG_EV_PASS] = 1'b1;
		if (eraseDone)
			flag_next[SRG_EV_ERASE] = 1'b1;
		if (memError)
			flag_next[SRG_EV_BUSERR] = 1'b1;
		// Track flipped locations; the pass end folds them into the state bit
		if (remCommit)
			done_next[physAddr] = 1'b1;
		if (passDone)
		begin
			inversion_next = !inversion_reg;
			done_next = '0;
		end
		// Erase start puts every register back, the key included
		if (eraseStart)
		begin
			ctrl_next = SRG_CTRL_RESET;
			key_next = SRG_KEY_RESET;
			flag_next = SRG_EV_RESET;
			mask_next = SRG_EV_RESET;
			inversion_next = 1'b0;
			done_next = '0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_reg <= SRG_CTRL_RESET;
			key_reg <= SRG_KEY_RESET;
			flag_reg <= SRG_EV_RESET;
			mask_reg <= SRG_EV_RESET;
			inversion_reg <= 1'b0;
			done_reg <= '0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			key_reg <= key_next;
			flag_reg <= flag_next;
			mask_reg <= mask_next;
			inversion_reg <= inversion_next;
			done_reg <= done_next;
		end
	end

	// Answer capture: every processor read is answered in the next cycle
	always_comb
	begin
		rdPending_next = memReq.read;
		rdZero_next = memReq.read && isWord && !erasing;
		rdErase_next = memReq.read && erasing;
		rdLanes_next = cpuLanes;
		rdInv_next = effInv;
		regRdata_next = 32'h0000_0000;
		if (regRead)
		begin
			case (regAddr)
				SRG_OFF_CTRL:
					regRdata_next[3:1] = ctrl_reg;
				SRG_OFF_KEY:
					regRdata_next[ADDR_W-1:0] = key_reg;
				SRG_OFF_STATUS:
				begin
					regRdata_next[SRG_STAT_INV] = inversion_reg;
					regRdata_next[SRG_STAT_REMBUSY] = (state_reg == SRG_REM_READ) || (state_reg == SRG_REM_WRITE);
					regRdata_next[SRG_STAT_ERASING] = erasing;
				end
				SRG_OFF_FLAG:
					regRdata_next[SRG_EV_W-1:0] = flag_reg;
				SRG_OFF_MASK:
					regRdata_next[SRG_EV_W-1:0] = mask_reg;
				default:
					regRdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdPending_reg <= 1'b0;
			rdZero_reg <= 1'b0;
			rdErase_reg <= 1'b0;
			rdLanes_reg <= 4'h0;
			rdInv_reg <= 1'b0;
			regRdata <= 32'h0000_0000;
		end
		else
		begin
			rdPending_reg <= rdPending_next;
			rdZero_reg <= rdZero_next;
			rdErase_reg <= rdErase_next;
			rdLanes_reg <= rdLanes_next;
			rdInv_reg <= rdInv_next;
			regRdata <= regRdata_next;
		end
	end

	// Undo the polarity, then compare only the lanes that were asked for
	assign rdBits = srg_lane_bits(rdLanes_reg);
	assign trueData = ramRdData[31:0] ^ {32{rdInv_reg}};
	assign trueComp = ramRdData[63:32] ^ {32{rdInv_reg}};
	assign mismatch = |((trueData ^ ~trueComp) & rdBits);

	// Answer outputs, straight from the memory and capture registers
	assign memValid = rdPending_reg;
	assign memError = rdPending_reg && (rdErase_reg || (!rdZero_reg && mismatch));
	assign memRdata = (rdPending_reg && !rdZero_reg && !memError) ? (trueData & rdBits) : 32'h0000_0000;

	// Level interrupt while any unmasked flag stands
	assign irq = |(flag_reg & mask_reg);

endmodule
`default_nettype wire

// >>> verification/srg_rtc_model.sv
// Partner model of the real-time counter: daily tick and tamper event pulses.
// Assumes the bench calls its tasks from a process that runs on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module srg_rtc_model
	import srg_pkg::*;
(
	input wire logic sys_clk,
	output logic dailyTickEvent,
	output logic tamperEvent
);
	// Both events idle low; the guard has no synchroniser, so pulses stay on sys_clk
	initial
	begin
		dailyTickEvent = 1'b0;
		tamperEvent = 1'b0;
	end

	// Daily periodic event, exactly one cycle wide
	task automatic pulseDaily();
		@(posedge sys_clk);
		dailyTickEvent <= 1'b1;
		@(posedge sys_clk);
		dailyTickEvent <= 1'b0;
	endtask

	// Tamper event, exactly one cycle wide
	task automatic pulseTamper();
		@(posedge sys_clk);
		tamperEvent <= 1'b1;
		@(posedge sys_clk);
		tamperEvent <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> verification/srg_guard_chk.sv
// Checker of the secure RAM guard top ports, bound to srg_guard_top.
// Assumes one clock domain; shadows only control bits needed to see tamper.
`timescale 1ns/1ps
`default_nettype none
module srg_guard_chk
	import srg_pkg::*;
#(
	parameter int ADDR_W = SRG_ADDR_W
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [31:0] regRdata,
	input wire srg_mem_req_t memReq,
	input wire logic [31:0] memRdata,
	input wire logic memValid,
	input wire logic memError,
	input wire logic dailyTickEvent,
	input wire logic tamperEvent,
	input wire logic irq
);
	logic enCopy_reg; // Shadow of module enable
	logic tamCopy_reg; // Shadow of tamper_erase_enable
	logic [6:0] eraseCnt_reg; // Cycles left in a tamper or software reset erase
	logic inErase; // Safely inside the erase, edges excluded

	// Shadow control; option bit frozen while enabled, as the guard must do
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			enCopy_reg <= 1'b0;
			tamCopy_reg <= 1'b0;
			eraseCnt_reg <= 7'h00;
		end
		else if (tamperEvent && enCopy_reg && tamCopy_reg)
		begin
			enCopy_reg <= 1'b0;
			tamCopy_reg <= 1'b0;
			eraseCnt_reg <= 7'h40;
		end
		else
		begin
			if (eraseCnt_reg != 7'h00)
				eraseCnt_reg <= eraseCnt_reg - 7'h01;
			if (regWrite && regAddr == SRG_OFF_CTRL)
			begin
				enCopy_reg <= regWdata[SRG_CTRL_ENABLE] && !regWdata[SRG_CTRL_SWRST];
				if (regWdata[SRG_CTRL_SWRST])
				begin
					// Software reset runs the same erase as an armed tamper
					tamCopy_reg <= 1'b0;
					eraseCnt_reg <= 7'h40;
				end
				else if (!enCopy_reg)
					tamCopy_reg <= regWdata[SRG_CTRL_TAMPER];
			end
		end
	end

	// First and last erase cycles left out so a one-cycle skew is tolerated
	assign inErase = eraseCnt_reg >= 7'h02 && eraseCnt_reg <= 7'h3F;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence armedTamper;
		tamperEvent && enCopy_reg && tamCopy_reg;
	endsequence
	sequence eraseRead;
		memReq.read && inErase;
	endsequence

	a_read_answer: assert property (memReq.read |=> memValid)
		else $error("read request got no answer");
	a_valid_cause: assert property (memValid |-> $past(memReq.read))
		else $error("answer without a read request");
	a_error_valid: assert property (memError |-> memValid)
		else $error("bus error outside an answer");
	// Outside an erase only: there every read, word reads too, must answer with an error
	a_word_read: assert property (memReq.read && memReq.size == SRG_SIZE_WORD && eraseCnt_reg == 7'h00
		|=> memRdata == 32'h0 && !memError)
		else $error("word read not zero");
	a_tamper_irq: assert property (armedTamper |=> (!irq) [*3])
		else $error("interrupt survived tamper erase");
	a_erase_read: assert property (eraseRead |=> memError)
		else $error("read during erase without error");
	a_erase_status: assert property (regRead && regAddr == SRG_OFF_STATUS && inErase |=> regRdata[SRG_STAT_ERASING])
		else $error("erase not shown in status");
	a_erase_ctrl: assert property (regRead && regAddr == SRG_OFF_CTRL && inErase |=> regRdata[3:0] == 4'h0)
		else $error("control not reset by erase");
	a_erase_key: assert property (regRead && regAddr == SRG_OFF_KEY && inErase |=> regRdata == 32'h0)
		else $error("key not reset by erase");
endmodule

bind srg_guard_top srg_guard_chk #(.ADDR_W(ADDR_W)) chk (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
	.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .memReq(memReq),
	.memRdata(memRdata), .memValid(memValid), .memError(memError), .dailyTickEvent(dailyTickEvent),
	.tamperEvent(tamperEvent), .irq(irq));
`default_nettype wire

// >>> verification/tb_secure_ram_guard.sv
// Self-checking bench of the secure RAM guard: register and memory tasks.
// Assumes srg_rtc_model supplies the events and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module tb_secure_ram_guard
	import srg_pkg::*;
;
	logic sys_clk, resetn, regWrite, regRead, memValid, memError, irq, dailyTickEvent, tamperEvent;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata, memRdata;
	srg_mem_req_t memReq; // Processor request
	int num_errors, check_count, i;
	logic [31:0] rd; // Last read data
	logic er, lastValid; // Last error and answer flags
	logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20}; // Last is unmapped

	srg_guard_top #(.ADDR_W(SRG_ADDR_W)) dut (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .memReq(memReq),
		.memRdata(memRdata), .memValid(memValid), .memError(memError), .dailyTickEvent(dailyTickEvent),
		.tamperEvent(tamperEvent), .irq(irq));
	srg_rtc_model rtc (.sys_clk(sys_clk), .dailyTickEvent(dailyTickEvent), .tamperEvent(tamperEvent));

	// 125 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Compare and count; x states never match
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task regWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task regRd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1;
		d = regRdata;
	endtask

	task memGo(input logic wr, input srg_size_t sz, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		memReq <= '{write: wr, read: !wr, size: sz, addr: a, wdata: d};
		@(posedge sys_clk);
		memReq <= '0;
		#1;
		rd = memRdata;
		er = memError;
		lastValid = memValid;
	endtask

	task memChk(input srg_size_t sz, input logic [7:0] a, input logic [31:0] x);
		memGo(1'b0, sz, a, 32'h0);
		chk("memValid", 32'h1, {31'h0, lastValid});
		chk("memRdata", x, rd);
		chk("memError", 32'h0, {31'h0, er});
	endtask

	// Each byte lane of word 1 holds its own pattern, or zero after erase
	task bytesChk(input logic z);
		for (int k = 0; k < 4; k++)
			memChk(SRG_SIZE_BYTE, 8'(4 + k), z ? 32'h0 : (32'h11 * (k + 1)) << (8 * k));
	endtask

	task irqChk(input logic x);
		#1;
		chk("irq", {31'h0, x}, {31'h0, irq});
	endtask

	// Pass with one processor read while it is still at location 0, then poll busy under a bound
	task runPass(input logic [31:0] x);
		int n;
		rtc.pulseDaily();
		memChk(SRG_SIZE_BYTE, 8'h05, x);
		rd = 32'h2;
		n = 0;
		while (rd[SRG_STAT_REMBUSY] && n < 200)
		begin
			regRd(SRG_OFF_STATUS, rd);
			n++;
		end
		chk("passBusy", 32'h0, {31'h0, rd[SRG_STAT_REMBUSY]});
	endtask

	task report_and_stop();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Hang guard: whole run needs well under 10000 cycles
	initial
	begin
		repeat (30000) @(posedge sys_clk);
		num_errors++;
		$display("ERROR watchdog expected finish seen timeout");
		report_and_stop();
	end

	initial
	begin
		regAddr = 8'h00;
		regWdata = 32'h0;
		regWrite = 1'b0;
		regRead = 1'b0;
		memReq = '0;
		resetn = 1'b0;
		num_errors = 0;
		check_count = 0;
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		// Software reset clears memory; wait out its 64 cycles
		regWr(SRG_OFF_CTRL, 32'h1);
		repeat (70) @(posedge sys_clk);
		for (i = 0; i < 6; i++)
		begin
			regRd(offs[i], rd);
			// The erase behind the software reset leaves its done flag standing
			chk("regReset", (i == 3) ? 32'h2 : 32'h0, rd);
		end
		$display("test reset done");
		// Byte and half stores, word write dropped, word read zero
		for (i = 0; i < 4; i++)
			memGo(1'b1, SRG_SIZE_BYTE, 8'(4 + i), (32'h11 * (i + 1)) << (8 * i));
		bytesChk(1'b0);
		memChk(SRG_SIZE_HALF, 8'h04, 32'h0000_2211);
		memChk(SRG_SIZE_HALF, 8'h06, 32'h4433_0000);
		memGo(1'b1, SRG_SIZE_HALF, 8'h0A, 32'hABCD_0000);
		memGo(1'b1, SRG_SIZE_WORD, 8'h0A, 32'hFFFF_FFFF);
		memChk(SRG_SIZE_HALF, 8'h0A, 32'hABCD_0000);
		memChk(SRG_SIZE_WORD, 8'h0A, 32'h0);
		$display("test access done");
		// Remanence option frozen once enabled; pass toggles inversion
		regWr(SRG_OFF_CTRL, 32'h4);
		regWr(SRG_OFF_CTRL, 32'h6);
		regWr(SRG_OFF_CTRL, 32'h2);
		regRd(SRG_OFF_CTRL, rd);
		chk("ctrl", 32'h6, rd);
		regWr(SRG_OFF_MASK, 32'h1);
		runPass(32'h0000_2200);
		regRd(SRG_OFF_STATUS, rd);
		chk("status", 32'h1, rd);
		regRd(SRG_OFF_FLAG, rd);
		chk("flags", 32'h3, rd);
		irqChk(1'b1);
		bytesChk(1'b0);
		regWr(SRG_OFF_MASK, 32'h0);
		irqChk(1'b0);
		regWr(SRG_OFF_MASK, 32'h1);
		irqChk(1'b1);
		regWr(SRG_OFF_FLAG, 32'h1);
		irqChk(1'b0);
		runPass(32'h0000_2200);
		regRd(SRG_OFF_STATUS, rd);
		chk("status", 32'h0, rd);
		bytesChk(1'b0);
		$display("test remanence done");
		// Tamper without the option armed leaves data alone
		rtc.pulseTamper();
		repeat (3) @(posedge sys_clk);
		memChk(SRG_SIZE_BYTE, 8'h05, 32'h0000_2200);
		regRd(SRG_OFF_CTRL, rd);
		chk("ctrl", 32'h6, rd);
		// Armed tamper aborts a running pass and erases everything
		regWr(SRG_OFF_CTRL, 32'h0);
		regWr(SRG_OFF_CTRL, 32'hC);
		regWr(SRG_OFF_CTRL, 32'hE);
		regWr(SRG_OFF_KEY, 32'h15);
		regRd(SRG_OFF_KEY, rd);
		chk("key", 32'h15, rd);
		// Unmask the old erase flag so the tamper has a live interrupt to clear
		regWr(SRG_OFF_MASK, 32'h2);
		irqChk(1'b1);
		rtc.pulseDaily();
		repeat (10) @(posedge sys_clk);
		rtc.pulseTamper();
		memGo(1'b0, SRG_SIZE_BYTE, 8'h05, 32'h0);
		chk("eraseError", 32'h1, {31'h0, er});
		regRd(SRG_OFF_STATUS, rd);
		chk("status", 32'h4, rd);
		regRd(SRG_OFF_KEY, rd);
		chk("key", 32'h0, rd);
		regRd(SRG_OFF_CTRL, rd);
		chk("ctrl", 32'h0, rd);
		irqChk(1'b0);
		repeat (70) @(posedge sys_clk);
		regRd(SRG_OFF_FLAG, rd);
		chk("eraseFlag", 32'h1, {31'h0, rd[SRG_EV_ERASE]});
		bytesChk(1'b1);
		// Fresh pass after the abort must cover every location again
		regWr(SRG_OFF_CTRL, 32'h4);
		regWr(SRG_OFF_CTRL, 32'h6);
		runPass(32'h0);
		regRd(SRG_OFF_STATUS, rd);
		chk("status", 32'h1, rd);
		bytesChk(1'b1);
		$display("test tamper done");
		report_and_stop();
	end
endmodule
`default_nettype wire
